// File: logic/rtctm_pkg.sv
// rtctm_pkg: offsets, field positions and reset values of the RTC timer
// and interrupt block; assumes a 32-bit register bus with byte addresses.
package rtctm_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] RTCTM_OFF_MASK = 8'h1C;
  localparam logic [7:0] RTCTM_OFF_RAW = 8'h20;
  localparam logic [7:0] RTCTM_OFF_MSK = 8'h24;
  localparam logic [7:0] RTCTM_OFF_CLR = 8'h28;
  localparam logic [7:0] RTCTM_OFF_DATA = 8'h2C;
  localparam logic [7:0] RTCTM_OFF_CTRL = 8'h30;
  localparam logic [7:0] RTCTM_OFF_RLD1 = 8'h34;
  localparam logic [7:0] RTCTM_OFF_RLD2 = 8'h38;
  localparam logic [7:0] RTCTM_OFF_PAT0 = 8'h3C;
  localparam logic [7:0] RTCTM_OFF_TRIM = 8'h50;

  // ==========================================================
  // field positions
  localparam int RTCTM_IRQ_CAL = 0;
  localparam int RTCTM_IRQ_CD = 1;
  localparam int RTCTM_CTRL_OS = 0;
  localparam int RTCTM_CTRL_EN = 1;
  localparam int RTCTM_CTRL_SS = 2;
  localparam int RTCTM_CTRL_PLEN = 4;
  localparam int RTCTM_CTRL_CLK = 11;
  localparam int RTCTM_CTRL_BYP = 12;
  localparam int RTCTM_TRIM_DIV = 0;
  localparam int RTCTM_TRIM_DROP = 16;

  // ==========================================================
  // widths and reset values
  localparam int RTCTM_PLEN_W = 7;
  localparam int RTCTM_DIV_W = 15;
  localparam int RTCTM_DROP_W = 10;
  localparam logic [31:0] RTCTM_DATA_RST = 32'h0FFFFFFF;
  localparam logic [14:0] RTCTM_DIV_RST = 15'h7FFF;
  localparam logic [9:0] RTCTM_DROP_RST = 10'h000;
  localparam logic [9:0] RTCTM_TRIM_PERIOD = 10'h3FF;
  localparam logic [1:0] RTCTM_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTCTM_RESP_DECERR = 2'h3;

endpackage

// File: logic/rtctm_tick.sv
// rtctm_tick: turns the slow reference clock pin into one-cycle tick
// pulses, raw and trimmed; assumes the pin is far slower than aclk.
`timescale 1ns/1ps
module rtctm_tick
  import rtctm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow_ref_clock,
  input wire logic [14:0] one_hz_divider,
  input wire logic [9:0] trim_pulse_drop_count,
  output logic raw_tick,
  output logic trim_tick
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic [14:0] div_cnt;
    logic [9:0] cyc;
    logic raw_tick;
    logic trim_tick;
  } rtctm_tick_t;

  rtctm_tick_t s;
  rtctm_tick_t next_s;

  // ==========================================================
  // synchroniser, edge detect, divider with pulse deletion
  always_comb begin
    next_s = s;
    next_s.sync1 = slow_ref_clock;
    next_s.sync2 = s.sync1;
    next_s.last = s.sync2;
    next_s.raw_tick = s.sync2 & ~s.last;
    next_s.trim_tick = 1'b0;
    if (s.sync2 && !s.last) begin
      if (s.cyc == RTCTM_TRIM_PERIOD - 10'h001) begin
        next_s.cyc = 10'h000;
      end else begin
        next_s.cyc = s.cyc + 10'h001;
      end
      // deleted pulses never reach the divider
      if (s.cyc >= trim_pulse_drop_count) begin
        if (s.div_cnt >= one_hz_divider) begin
          next_s.div_cnt = 15'h0000;
          next_s.trim_tick = 1'b1;
        end else begin
          next_s.div_cnt = s.div_cnt + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign raw_tick = s.raw_tick;
  assign trim_tick = s.trim_tick;

endmodule

// File: logic/rtctm_timer.sv
// rtctm_timer: countdown timer with pattern-chosen reloads, plus the
// calendar and timer interrupt flags, behind an AXI4-Lite slave.
// assumes calendar_match is a one-cycle pulse from aclk-domain logic.
//
// Behaviour
// - mask bit 0 enables the calendar interrupt, cleared at reset.
// - mask bit 1 enables the countdown interrupt, cleared at reset.
// - raw status shows both event flags regardless of mask.
// - masked status is raw AND enable and drives both interrupt outputs.
// - writing 1 to clear bits drops the flag; 0 does nothing.
// - periodic mode: at zero raise event, reload, keep counting.
// - one-shot mode: at zero raise event, then stop.
// - run-enable takes effect on the next slow tick; reads return it.
// - stopped counter holds its value.
// - writing a reload value while stopped sets run-enable.
// - one-shot zero clears run-enable in hardware.
// - with self-start set, reload or pattern writes set run-enable.
// - seven-bit pattern length bounds the pattern pointer.
// - clock select picks raw or trimmed slow clock.
// - gating bypass keeps the timer clock running always.
// - two 32-bit reload values, reset to zero.
// - pattern words for bits 31:0 and 63:32, reset to zero.
// - data register shows counter, reset 0x0FFFFFFF.
// - pattern words for bits 95:64 and 127:96 extend it.
// - trimmed clock is divider+1 with pulse deletion per 1023.
`timescale 1ns/1ps
module rtctm_timer
  import rtctm_pkg::*;
#(
  parameter int PAT_WORDS = 4
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic slow_ref_clock,
  input wire logic calendar_match,
  output logic calendar_irq_out,
  output logic countdown_irq_out,
  output logic timer_clock_active
);

  // refuse pattern sizes that the word decode cannot serve
  if (PAT_WORDS < 1 || PAT_WORDS > 4) begin : g_bad_words
    $error("PAT_WORDS must lie in 1..4");
  end

  typedef struct packed {
    logic [1:0] irq_en;
    logic cal_flag;
    logic cd_flag;
    logic cal_irq;
    logic cd_irq;
    logic single_run_select;
    logic en;
    logic running;
    logic self_start;
    logic [6:0] reload_pattern_length;
    logic clk_sel;
    logic bypass;
    logic [31:0] reload1;
    logic [31:0] reload2;
    logic [127:0] pattern;
    logic [6:0] ptr;
    logic [31:0] count;
    logic [14:0] divider;
    logic [9:0] drop;
    logic clk_active;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_rdy;
    logic w_rdy;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } rtctm_state_t;

  rtctm_state_t s;
  rtctm_state_t next_s;
  logic raw_tick;
  logic trim_tick;
  logic tick;
  logic zero_hit;
  logic wr_commit;
  logic [31:0] wr_mask;
  logic [31:0] reload_sel;

  rtctm_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow_ref_clock(slow_ref_clock),
    .one_hz_divider(s.divider),
    .trim_pulse_drop_count(s.drop),
    .raw_tick(raw_tick),
    .trim_tick(trim_tick)
  );

  // ==========================================================
  // timer clock: selection and gating
  // gated: ticks only reach the counter while running, starting or bypassed
  assign tick = (s.clk_sel ? trim_tick : raw_tick)
    & (s.bypass | s.en | s.running);
  assign zero_hit = tick && s.running && s.count == 32'h00000000;
  assign reload_sel = s.pattern[s.ptr] ? s.reload2 : s.reload1;
  assign wr_commit = s.aw_have && s.w_have && !s.b_valid;
  assign wr_mask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}},
                    {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (dat & msk);
  endfunction

  function automatic logic [31:0] read_reg(input rtctm_state_t st,
                                           input logic [7:0] a,
                                           output logic hit);
    logic [7:0] pidx;
    pidx = (a - RTCTM_OFF_PAT0) >> 2;
    hit = 1'b1;
    read_reg = 32'h00000000;
    case (a)
      RTCTM_OFF_MASK: read_reg[1:0] = st.irq_en;
      RTCTM_OFF_RAW: read_reg[1:0] = {st.cd_flag, st.cal_flag};
      RTCTM_OFF_MSK: read_reg[1:0] = {st.cd_irq, st.cal_irq};
      RTCTM_OFF_CLR: read_reg = 32'h00000000;
      RTCTM_OFF_DATA: read_reg = st.count;
      RTCTM_OFF_CTRL: begin
        read_reg[RTCTM_CTRL_OS] = st.single_run_select;
        read_reg[RTCTM_CTRL_EN] = st.en;
        read_reg[RTCTM_CTRL_SS] = st.self_start;
        read_reg[RTCTM_CTRL_PLEN +: RTCTM_PLEN_W] =
          st.reload_pattern_length;
        read_reg[RTCTM_CTRL_CLK] = st.clk_sel;
        read_reg[RTCTM_CTRL_BYP] = st.bypass;
      end
      RTCTM_OFF_RLD1: read_reg = st.reload1;
      RTCTM_OFF_RLD2: read_reg = st.reload2;
      RTCTM_OFF_TRIM: begin
        read_reg[RTCTM_TRIM_DIV +: RTCTM_DIV_W] = st.divider;
        read_reg[RTCTM_TRIM_DROP +: RTCTM_DROP_W] = st.drop;
      end
      default: begin
        if (a >= RTCTM_OFF_PAT0 && a[1:0] == 2'h0 &&
            pidx < 8'(PAT_WORDS)) begin
          read_reg = st.pattern[pidx[1:0] * 32 +: 32];
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [7:0] a;
    logic [7:0] pidx;
    logic [31:0] d;
    logic rd_hit;
    logic pat_wr;
    logic load_wr;
    a = s.aw_addr;
    pidx = (a - RTCTM_OFF_PAT0) >> 2;
    d = s.w_data;
    rd_hit = 1'b0;
    pat_wr = 1'b0;
    load_wr = 1'b0;
    next_s = s;

    // countdown on the selected slow tick
    if (tick) begin
      if (s.running) begin
        if (s.count == 32'h00000000) begin
          if (s.single_run_select) begin
            next_s.en = 1'b0;
            next_s.running = 1'b0;
          end else begin
            next_s.count = reload_sel;
            if (s.ptr + 7'h01 >= s.reload_pattern_length) begin
              next_s.ptr = 7'h00;
            end else begin
              next_s.ptr = s.ptr + 7'h01;
            end
            next_s.running = s.en;
          end
        end else begin
          next_s.count = s.count - 32'h00000001;
          next_s.running = s.en;
        end
      end else begin
        next_s.running = s.en;
      end
    end

    // software writes; hardware sets of the flags below win
    if (wr_commit) begin
      next_s.b_valid = 1'b1;
      next_s.b_resp = RTCTM_RESP_OKAY;
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      case (a)
        RTCTM_OFF_MASK: begin
          if (s.w_strb[0]) begin
            next_s.irq_en = d[1:0];
          end
        end
        RTCTM_OFF_CLR: begin
          if (s.w_strb[0] && d[RTCTM_IRQ_CAL]) begin
            next_s.cal_flag = 1'b0;
          end
          if (s.w_strb[0] && d[RTCTM_IRQ_CD]) begin
            next_s.cd_flag = 1'b0;
          end
        end
        RTCTM_OFF_CTRL: begin
          if (s.w_strb[0]) begin
            next_s.single_run_select = d[RTCTM_CTRL_OS];
            next_s.en = d[RTCTM_CTRL_EN];
            next_s.self_start = d[RTCTM_CTRL_SS];
          end
          next_s.reload_pattern_length = 7'(merge(
            32'(s.reload_pattern_length) << RTCTM_CTRL_PLEN, d,
            wr_mask) >> RTCTM_CTRL_PLEN);
          if (s.w_strb[1]) begin
            next_s.clk_sel = d[RTCTM_CTRL_CLK];
            next_s.bypass = d[RTCTM_CTRL_BYP];
          end
        end
        RTCTM_OFF_RLD1: begin
          next_s.reload1 = merge(s.reload1, d, wr_mask);
          load_wr = 1'b1;
        end
        RTCTM_OFF_RLD2: begin
          next_s.reload2 = merge(s.reload2, d, wr_mask);
          load_wr = 1'b1;
        end
        RTCTM_OFF_TRIM: begin
          next_s.divider = 15'(merge(32'(s.divider), d, wr_mask));
          next_s.drop = 10'(merge(32'(s.drop),
            d >> RTCTM_TRIM_DROP, wr_mask >> RTCTM_TRIM_DROP));
        end
        RTCTM_OFF_RAW, RTCTM_OFF_MSK, RTCTM_OFF_DATA: begin
          next_s.b_resp = RTCTM_RESP_OKAY;
        end
        default: begin
          if (a >= RTCTM_OFF_PAT0 && a[1:0] == 2'h0 &&
              pidx < 8'(PAT_WORDS)) begin
            next_s.pattern[pidx[1:0] * 32 +: 32] = merge(
              s.pattern[pidx[1:0] * 32 +: 32], d, wr_mask);
            pat_wr = 1'b1;
          end else begin
            next_s.b_resp = RTCTM_RESP_DECERR;
          end
        end
      endcase
      // a stopped counter picks up the freshly written value
      if (load_wr && !s.running) begin
        next_s.count = merge(a == RTCTM_OFF_RLD1 ? s.reload1 : s.reload2,
                             d, wr_mask);
        next_s.en = 1'b1;
      end
      if ((load_wr || pat_wr) && s.self_start) begin
        next_s.en = 1'b1;
      end
    end

    // event flags: set after clear so a same-cycle event survives
    if (zero_hit) begin
      next_s.cd_flag = 1'b1;
    end
    if (calendar_match) begin
      next_s.cal_flag = 1'b1;
    end
    next_s.cal_irq = next_s.cal_flag & next_s.irq_en[RTCTM_IRQ_CAL];
    next_s.cd_irq = next_s.cd_flag & next_s.irq_en[RTCTM_IRQ_CD];
    next_s.clk_active = next_s.bypass | next_s.en | next_s.running;

    // bus handshakes
    if (awvalid && s.aw_rdy) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && s.w_rdy) begin
      next_s.w_have = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.b_valid && bready) begin
      next_s.b_valid = 1'b0;
    end
    if (s.r_valid && rready) begin
      next_s.r_valid = 1'b0;
    end
    if (arvalid && s.ar_rdy) begin
      next_s.r_valid = 1'b1;
      next_s.r_data = read_reg(s, araddr, rd_hit);
      next_s.r_resp = rd_hit ? RTCTM_RESP_OKAY : RTCTM_RESP_DECERR;
    end
    next_s.aw_rdy = !next_s.aw_have && !next_s.b_valid;
    next_s.w_rdy = !next_s.w_have && !next_s.b_valid;
    next_s.ar_rdy = !next_s.r_valid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.count <= RTCTM_DATA_RST;
      s.divider <= RTCTM_DIV_RST;
      s.drop <= RTCTM_DROP_RST;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.aw_rdy;
  assign wready = s.w_rdy;
  assign bvalid = s.b_valid;
  assign bresp = s.b_resp;
  assign arready = s.ar_rdy;
  assign rvalid = s.r_valid;
  assign rdata = s.r_data;
  assign rresp = s.r_resp;
  assign calendar_irq_out = s.cal_irq;
  assign countdown_irq_out = s.cd_irq;
  assign timer_clock_active = s.clk_active;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_zero_hit;
    tick && s.running && s.count == 32'h00000000;
  endsequence

  sequence s_clr_cd;
    wr_commit && s.aw_addr == RTCTM_OFF_CLR && s.w_strb[0] &&
      s.w_data[RTCTM_IRQ_CD];
  endsequence

  a_event_sets_flag: assert property (
    s_zero_hit |=> s.cd_flag ##1 s.cd_flag || $past(wr_commit))
    else $error("timer flag not set at zero");
  a_oneshot_stops: assert property (
    s_zero_hit ##0 s.single_run_select && !wr_commit
      |=> !s.running && !s.en)
    else $error("one-shot timer kept running");
  a_periodic_reload: assert property (
    s_zero_hit ##0 !s.single_run_select && !wr_commit
      |=> s.count == $past(reload_sel))
    else $error("periodic reload value wrong");
  a_stopped_holds: assert property (
    !s.running && !wr_commit |=> $stable(s.count))
    else $error("stopped counter moved");
  a_clear_drops: assert property (
    s_clr_cd ##0 !zero_hit |=> !s.cd_flag)
    else $error("clear did not drop timer flag");
  a_cd_mask_gate: assert property (
    s.cd_flag && !s.irq_en[RTCTM_IRQ_CD] |-> ##[0:1] !countdown_irq_out)
    else $error("masked timer interrupt reached output");
  a_cal_irq_out: assert property (
    calendar_match |=> calendar_irq_out == s.irq_en[RTCTM_IRQ_CAL])
    else $error("calendar output disagrees with mask");
  a_en_starts: assert property (
    s.en && tick && !s.running |=> s.running)
    else $error("run-enable did not start timer on tick");
  a_self_start: assert property (
    wr_commit && s.self_start && (s.aw_addr == RTCTM_OFF_PAT0 ||
      s.aw_addr == RTCTM_OFF_PAT0 + 8'h04) |=> s.en)
    else $error("self-start did not set run-enable");
  a_read_answers: assert property (
    arvalid && arready |=> rvalid && !arready)
    else $error("read not answered in one cycle");

endmodule

// File: tb/rtctm_timer_bench.sv
// rtctm_timer_bench: self-checking bench for the timer and interrupt
// block; assumes rtctm_pkg and rtctm_timer are compiled before it.
`timescale 1ns/1ps
module rtctm_timer_bench;
  import rtctm_pkg::*;
  // ==========================================================
  // stimulus signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, mx;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid;
  logic slow_ref_clock, calendar_match;
  logic calendar_irq_out, countdown_irq_out, timer_clock_active;
  logic [2:0] scnt;
  int miscompares, compares, cyc;
  localparam int LIMIT = 20000;

  rtctm_timer #(.PAT_WORDS(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .slow_ref_clock(slow_ref_clock), .calendar_match(calendar_match),
    .calendar_irq_out(calendar_irq_out),
    .countdown_irq_out(countdown_irq_out),
    .timer_clock_active(timer_clock_active));

  // ==========================================================
  // clock, slow reference (8 aclk per period) and timeout
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    scnt <= scnt + 3'h1;
    if (scnt == 3'h3) begin
      scnt <= 3'h0;
      slow_ref_clock <= ~slow_ref_clock;
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      $display("MISMATCH t=%0t timeout", $time);
      miscompares++;
      results();
    end
  end

  // ==========================================================
  // compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t value %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t resp %h want %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // bus tasks; bready and rready stay high for the whole run
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    bit aw_done, w_done;
    int n;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        rs = bresp;
        return;
      end
    end
    chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        return;
      end
    end
    chk(32'h0, 32'h1);
  endtask
  task automatic wrok(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, r);
    chkr(r, RTCTM_RESP_OKAY);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic wait_cd_flag();
    int n;
    for (n = 0; n < 100; n++) begin
      rd(RTCTM_OFF_RAW, d, r);
      if (d[1] === 1'b1) return;
    end
    chk(32'h0, 32'h2);
  endtask
  task automatic peak(input int reads);
    mx = 32'h0;
    repeat (reads) begin
      rd(RTCTM_OFF_DATA, d, r);
      if (d > mx) mx = d;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    int i;
    for (i = 0; i < 11; i++)
      rdchk(8'h1C + 8'(4 * i), (i == 4) ? RTCTM_DATA_RST : 32'h0);
    rd(8'h60, d, r);
    chkr(r, RTCTM_RESP_DECERR);
    chk(d, 32'h0);
    wr(8'h60, 32'h3, r);
    chkr(r, RTCTM_RESP_DECERR);
    wrok(RTCTM_OFF_RAW, 32'h3);
    rdchk(RTCTM_OFF_RAW, 32'h0);
    $display("test reset_values done");
  endtask

  task automatic t_calendar();
    calendar_match <= 1'b1;
    @(posedge aclk);
    calendar_match <= 1'b0;
    rdchk(RTCTM_OFF_RAW, 32'h1);
    rdchk(RTCTM_OFF_MSK, 32'h0);
    chk(32'(calendar_irq_out), 32'h0);
    wrok(RTCTM_OFF_MASK, 32'h1);
    rdchk(RTCTM_OFF_MSK, 32'h1);
    chk(32'(calendar_irq_out), 32'h1);
    wrok(RTCTM_OFF_CLR, 32'h0);
    rdchk(RTCTM_OFF_RAW, 32'h1);
    wrok(RTCTM_OFF_CLR, 32'h1);
    rdchk(RTCTM_OFF_RAW, 32'h0);
    chk(32'(calendar_irq_out), 32'h0);
    wrok(RTCTM_OFF_MASK, 32'h0);
    $display("test calendar_flag done");
  endtask

  task automatic t_oneshot();
    wrok(RTCTM_OFF_CTRL, 32'h1);
    wrok(RTCTM_OFF_RLD1, 32'h3);
    rdchk(RTCTM_OFF_CTRL, 32'h3);
    wait_cd_flag();
    rdchk(RTCTM_OFF_CTRL, 32'h1);
    rdchk(RTCTM_OFF_DATA, 32'h0);
    repeat (40) @(posedge aclk);
    rdchk(RTCTM_OFF_DATA, 32'h0);
    chk(32'(countdown_irq_out), 32'h0);
    wrok(RTCTM_OFF_MASK, 32'h2);
    rdchk(RTCTM_OFF_MSK, 32'h2);
    chk(32'(countdown_irq_out), 32'h1);
    wrok(RTCTM_OFF_CLR, 32'h2);
    rdchk(RTCTM_OFF_RAW, 32'h0);
    chk(32'(countdown_irq_out), 32'h0);
    $display("test one_shot done");
  endtask

  task automatic t_pattern();
    wrok(RTCTM_OFF_CTRL, 32'h20);
    wrok(RTCTM_OFF_RLD1, 32'h1);
    // let it run, or the second reload write would load the counter
    repeat (20) @(posedge aclk);
    wrok(RTCTM_OFF_RLD2, 32'h6);
    repeat (40) @(posedge aclk);
    peak(40);
    chk(mx, 32'h1);
    wrok(RTCTM_OFF_PAT0, 32'h2);
    peak(60);
    chk(mx, 32'h6);
    rd(RTCTM_OFF_RAW, d, r);
    chk(d & 32'h2, 32'h2);
    rdchk(RTCTM_OFF_CTRL, 32'h22);
    wrok(RTCTM_OFF_CTRL, 32'h4);
    repeat (20) @(posedge aclk);
    rdchk(RTCTM_OFF_CTRL, 32'h4);
    wrok(RTCTM_OFF_PAT0 + 8'h4, 32'h0);
    rdchk(RTCTM_OFF_CTRL, 32'h6);
    wrok(RTCTM_OFF_CLR, 32'h2);
    $display("test pattern_reload done");
  endtask

  task automatic t_clocks();
    wrok(RTCTM_OFF_CTRL, 32'h1000);
    repeat (30) @(posedge aclk);
    chk(32'(timer_clock_active), 32'h1);
    wrok(RTCTM_OFF_CTRL, 32'h0);
    repeat (30) @(posedge aclk);
    chk(32'(timer_clock_active), 32'h0);
    wrok(RTCTM_OFF_CTRL, 32'h800);
    wrok(RTCTM_OFF_RLD1, 32'h14);
    repeat (100) @(posedge aclk);
    rdchk(RTCTM_OFF_DATA, 32'h14);
    wrok(RTCTM_OFF_CTRL, 32'h2);
    repeat (100) @(posedge aclk);
    rd(RTCTM_OFF_DATA, d, r);
    chk(32'(d < 32'h14), 32'h1);
    $display("test clock_select done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    miscompares = 0;
    compares = 0;
    cyc = 0;
    scnt = 3'h0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    slow_ref_clock = 1'b0;
    calendar_match = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_calendar();
    t_oneshot();
    t_pattern();
    t_clocks();
    results();
  end
endmodule
